// >>> logic/cias_top.sv
// interrupt entry sequencer: stacking, acknowledge cycle, spurious handling
// Summary of operation
// - take a pending valid request only at a boundary, no higher exception busy
// - stack the status word first, then the program counter, before acknowledging
// - function code outputs read all ones during the acknowledge cycle
// - address bits 23:20 and 19:16 all ones, marking an acknowledge cycle
// - address bits 15:4 all ones during the acknowledge cycle
// - address bits 3:1 carry the acknowledged level, bit 0 high
// - acknowledged level copied from the address into the priority mask
// - no contender: monitor raises bus error, spurious exception follows
// - status word layout: trace, supervisor, mask, five condition bits
// - reset clears trace, sets supervisor, mask all ones
// - user privilege reaches only the condition byte
// - supervisor reads and changes the whole status word
// - and immediate masks the condition byte
// - and immediate masks the whole word, supervisor only
`timescale 1ns/100ps
module cias_top import cias_pkg::*; #(
	parameter int SPUR_WAIT = SPUR_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic irq_pending,
	input wire logic [2:0] irq_level,
	input wire logic at_boundary,
	input wire logic higher_exc_busy,
	input wire logic [31:0] pc_value,
	input wire logic push_done,
	input wire logic contend_pin,
	input wire logic term_pin,
	input wire logic [7:0] data_pin,
	input wire logic sr_op_valid,
	input cias_op_type sr_op,
	input wire logic [15:0] sr_wdata,
	input wire logic cc_load,
	input wire logic [PSW_CC_W-1:0] cc_in,
	output logic push_valid,
	output logic [31:0] push_data,
	output logic [2:0] function_code_outputs,
	output logic [23:0] ack_addr,
	output logic ack_cycle,
	output logic bus_error_strobe,
	output logic spurious_exc,
	output logic vector_valid,
	output logic [7:0] vector_num,
	output logic [15:0] processor_status_word,
	output logic [15:0] sr_rdata,
	output logic priv_violation
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT,
		ST_PUSH_SR,
		ST_PUSH_PC,
		ST_ACK
	} cias_state_type;

	cias_state_type st;
	cias_state_type next_st;
	logic [2:0] lvl;
	logic contended;
	logic ack_start;
	logic contend_m;
	logic contend_s;
	logic term_m;
	logic term_s;
	logic [7:0] data_m;
	logic [7:0] data_s;
	logic spur_to;

	// pins pass two flops; data settles in the same cycle as termination
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			contend_m <= 1'b0;
			contend_s <= 1'b0;
			term_m <= 1'b0;
			term_s <= 1'b0;
			data_m <= 8'h00;
			data_s <= 8'h00;
		end else begin
			contend_m <= contend_pin;
			contend_s <= contend_m;
			term_m <= term_pin;
			term_s <= term_m;
			data_m <= data_pin;
			data_s <= data_m;
		end
	end

	wire [2:0] cur_mask = processor_status_word[PSW_IP_HI:PSW_IP_LO];
	// level seven always gets through the mask
	wire req_valid = irq_pending && irq_level != 3'h0
		&& (irq_level > cur_mask || irq_level == LEVEL_NMI);
	// wait for boundary and no higher exception
	wire may_start = at_boundary && !higher_exc_busy;
	wire sr_saved = st == ST_PUSH_SR && push_done;
	wire pc_saved = st == ST_PUSH_PC && push_done;
	wire ack_done = st == ST_ACK && contended && term_s;
	// monitor runs only while nobody contends
	wire spur_run = st == ST_ACK && !contended && !contend_s && !spur_to;
	wire spur_end = st == ST_ACK && spur_to;

	// status word stacked, then program counter
	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: begin
				if (req_valid) begin
					next_st = may_start ? ST_PUSH_SR : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (may_start) begin
					next_st = ST_PUSH_SR;
				end
			end
			ST_PUSH_SR: begin
				if (push_done) begin
					next_st = ST_PUSH_PC;
				end
			end
			ST_PUSH_PC: begin
				if (push_done) begin
					next_st = ST_ACK;
				end
			end
			ST_ACK: begin
				if (ack_done || spur_end) begin
					next_st = ST_IDLE;
				end
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
	end

	wire next_ack = next_st == ST_ACK;
	wire next_push = next_st == ST_PUSH_SR || next_st == ST_PUSH_PC;
	// request level frozen once accepted, so a change cannot skew the cycle
	wire [2:0] next_lvl = (st == ST_IDLE && req_valid) ? irq_level : lvl;
	wire [31:0] next_push_data = (next_st == ST_PUSH_SR) ?
		{16'h0000, processor_status_word} : pc_value;
	wire [2:0] next_fc = next_ack ? FC_CPU_SPACE : FC_IDLE;
	wire [23:0] next_addr = next_ack ? cias_ack_addr(next_lvl) : 24'h000000;
	wire next_contended = st == ST_ACK && (contended || contend_s);

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st <= ST_IDLE;
			lvl <= 3'h0;
			contended <= 1'b0;
			ack_start <= 1'b0;
			push_valid <= 1'b0;
			push_data <= 32'h00000000;
			function_code_outputs <= FC_IDLE;
			ack_addr <= 24'h000000;
			ack_cycle <= 1'b0;
			spurious_exc <= 1'b0;
			vector_valid <= 1'b0;
			vector_num <= 8'h00;
		end else begin
			st <= next_st;
			lvl <= next_lvl;
			contended <= next_contended;
			ack_start <= next_ack && st != ST_ACK;
			push_valid <= next_push;
			push_data <= next_push_data;
			function_code_outputs <= next_fc;
			ack_addr <= next_addr;
			ack_cycle <= next_ack;
			spurious_exc <= spur_end;
			vector_valid <= ack_done;
			vector_num <= ack_done ? data_s : vector_num;
		end
	end

	cias_spur_mon #(
		.CYCLES(SPUR_WAIT)
	) u_mon (
		.mclk(mclk),
		.rst_b(rst_b),
		.run(spur_run),
		.timeout(spur_to)
	);
	assign bus_error_strobe = spur_to;

	// mask taken from the address bus
	cias_status_word u_psw (
		.mclk(mclk),
		.rst_b(rst_b),
		.op_valid(sr_op_valid),
		.op(sr_op),
		.wdata(sr_wdata),
		.entry_set(sr_saved),
		.mask_load(ack_start),
		.mask_val(ack_addr[3:1]),
		.cc_load(cc_load),
		.cc_in(cc_in),
		.psw(processor_status_word),
		.rdata(sr_rdata),
		.priv_err(priv_violation)
	);

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence sr_saved_s;
		st == ST_PUSH_SR && push_done;
	endsequence
	sequence pc_phase_s;
		st == ST_PUSH_PC && push_valid && push_data == $past(pc_value);
	endsequence
	sequence ack_open_s;
		$rose(ack_cycle);
	endsequence

	start_gate_a: assert property (next_st == ST_PUSH_SR && st != ST_PUSH_SR
		|-> at_boundary && !higher_exc_busy) else $error("entry off boundary");
	push_order_a: assert property (sr_saved_s |=> pc_phase_s)
		else $error("counter not stacked after status");
	sr_stack_a: assert property ($rose(push_valid)
		|-> push_data[15:0] == processor_status_word) else $error("status not stacked");
	ack_after_push_a: assert property (ack_open_s |-> $past(st) == ST_PUSH_PC)
		else $error("ack before stacking");
	ack_open_a: assert property (pc_saved |=> ack_cycle && ack_start)
		else $error("ack not opened after counter stacked");
	fc_space_a: assert property (ack_cycle |-> function_code_outputs == 3'h7)
		else $error("function code not cpu space");
	addr_top_a: assert property (ack_cycle |-> ack_addr[23:16] == 8'hFF)
		else $error("upper address not ones");
	addr_mid_a: assert property (ack_cycle |-> ack_addr[15:4] == 12'hFFF)
		else $error("middle address not ones");
	addr_level_a: assert property (ack_cycle |-> ack_addr[3:1] == lvl && ack_addr[0])
		else $error("level or bit zero wrong");
	mask_latch_a: assert property (ack_open_s |=> ##1
		processor_status_word[10:8] == $past(ack_addr[3:1], 2))
		else $error("mask not latched");
	bus_error_strobe_cause_a: assert property (bus_error_strobe |-> ack_cycle && !contended)
		else $error("bus error with contender");
	spur_follow_a: assert property (bus_error_strobe |=> spurious_exc && !ack_cycle)
		else $error("no spurious exception");
	entry_bits_a: assert property (sr_saved_s |=> processor_status_word[15:13] == 3'h1)
		else $error("entry bits wrong");
	vector_take_a: assert property (ack_done |=> vector_valid && vector_num == $past(data_s))
		else $error("vector lost");
endmodule : cias_top

// >>> common/cias_pkg.sv
// shared constants and types for interrupt entry and status word
package cias_pkg;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SPUR_TIME_NS = 640;
	localparam int SPUR_CYCLES = (SPUR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] FC_CPU_SPACE = 3'h7;
	localparam logic [2:0] FC_IDLE = 3'h0;
	localparam logic [3:0] ADDR_HI_ONES = 4'hF;
	localparam logic [3:0] ADDR_ACK_TYPE = 4'hF;
	localparam logic [11:0] ADDR_MID_ONES = 12'hFFF;
	localparam logic ADDR_BIT0 = 1'b1;
	localparam logic [2:0] LEVEL_NMI = 3'h7;
	localparam int PSW_T_HI = 15;
	localparam int PSW_T_LO = 14;
	localparam int PSW_S = 13;
	localparam int PSW_IP_HI = 10;
	localparam int PSW_IP_LO = 8;
	localparam int PSW_CC_W = 5;
	localparam logic [15:0] PSW_IMPL_MASK = 16'hE71F;
	localparam logic [15:0] PSW_RESET = 16'h2700;
	typedef enum logic [2:0] {
		CIAS_OP_READ,
		CIAS_OP_WRITE_SR,
		CIAS_OP_WRITE_CCR,
		CIAS_OP_AND_IMMEDIATE_OP_CCR,
		CIAS_OP_AND_IMMEDIATE_OP_SR
	} cias_op_type;
	function automatic logic [23:0] cias_ack_addr(input logic [2:0] level);
		cias_ack_addr = {ADDR_HI_ONES, ADDR_ACK_TYPE, ADDR_MID_ONES, level, ADDR_BIT0};
	endfunction : cias_ack_addr
endpackage : cias_pkg

// >>> logic/cias_spur_mon.sv
// spurious interrupt monitor: timeout while an acknowledge goes unanswered
`timescale 1ns/100ps
module cias_spur_mon import cias_pkg::*; #(
	parameter int CYCLES = SPUR_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic run,
	output logic timeout
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt;
	wire last = cnt == CW'(CYCLES - 1);
	wire [CW-1:0] next_cnt = (run && !last) ? cnt + CW'(1) : '0;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			timeout <= 1'b0;
		end else begin
			cnt <= next_cnt;
			timeout <= run && last;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// a pulse only at the end of a full unbroken count
	mon_cause_a: assert property (timeout |-> $past(run) && $past(cnt) == CW'(CYCLES - 1))
		else $error("monitor timeout without full count");
endmodule : cias_spur_mon

// >>> logic/cias_status_word.sv
// processor status word with privileged access and immediate masking
`timescale 1ns/100ps
module cias_status_word import cias_pkg::*; (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic op_valid,
	input cias_op_type op,
	input wire logic [15:0] wdata,
	input wire logic entry_set,
	input wire logic mask_load,
	input wire logic [2:0] mask_val,
	input wire logic cc_load,
	input wire logic [PSW_CC_W-1:0] cc_in,
	output logic [15:0] psw,
	output logic [15:0] rdata,
	output logic priv_err
);
	wire sup = psw[PSW_S];
	wire sys_op = op_valid && (op == CIAS_OP_WRITE_SR || op == CIAS_OP_AND_IMMEDIATE_OP_SR);
	wire [15:0] wr_sr = wdata & PSW_IMPL_MASK;
	wire [15:0] wr_ccr = {psw[15:8], wdata[7:0] & PSW_IMPL_MASK[7:0]};
	wire [15:0] and_immediate_op_ccr = {psw[15:8], psw[7:0] & wdata[7:0]};
	wire [15:0] and_immediate_op_sr = psw & wdata;
	wire [15:0] op_val = !op_valid ? psw :
		(op == CIAS_OP_WRITE_SR && sup) ? wr_sr :
		(op == CIAS_OP_WRITE_CCR) ? wr_ccr :
		(op == CIAS_OP_AND_IMMEDIATE_OP_CCR) ? and_immediate_op_ccr :
		(op == CIAS_OP_AND_IMMEDIATE_OP_SR && sup) ? and_immediate_op_sr : psw;
	wire [15:0] cc_val = (cc_load && !op_valid) ? {psw[15:PSW_CC_W], cc_in} : op_val;
	wire [15:0] ip_val = mask_load ?
		{cc_val[15:PSW_IP_HI+1], mask_val, cc_val[PSW_IP_LO-1:0]} : cc_val;
	wire [15:0] next_psw = entry_set ? {2'b00, 1'b1, ip_val[PSW_S-1:0]} : ip_val;
	wire [15:0] next_rdata = (op_valid && op == CIAS_OP_READ) ?
		(sup ? psw : {8'h00, psw[7:0]}) : rdata;

	// reset trace clear, supervisor, mask ones
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			psw <= PSW_RESET;
			rdata <= 16'h0000;
			priv_err <= 1'b0;
		end else begin
			psw <= next_psw;
			rdata <= next_rdata;
			priv_err <= sys_op && !sup;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	psw_layout_a: assert property ((psw & ~PSW_IMPL_MASK) == 16'h0000)
		else $error("unimplemented status bit set");
	and_immediate_op_ccr_a: assert property (op_valid && op == CIAS_OP_AND_IMMEDIATE_OP_CCR && !entry_set && !mask_load
		|=> psw[7:0] == ($past(psw[7:0]) & $past(wdata[7:0])))
		else $error("condition byte and wrong");
	and_immediate_op_sr_a: assert property (op_valid && op == CIAS_OP_AND_IMMEDIATE_OP_SR && sup && !entry_set
		&& !mask_load |=> psw == ($past(psw) & $past(wdata)))
		else $error("status and wrong");
	user_guard_a: assert property (sys_op && !sup && !entry_set && !mask_load
		|=> psw[15:8] == $past(psw[15:8]) && priv_err)
		else $error("user changed system byte");
	user_read_a: assert property (op_valid && op == CIAS_OP_READ && !sup
		|=> rdata[15:8] == 8'h00) else $error("user saw system byte");
	sup_write_a: assert property (op_valid && op == CIAS_OP_WRITE_SR && sup && !entry_set
		&& !mask_load |=> psw == ($past(wdata) & PSW_IMPL_MASK))
		else $error("supervisor write lost");
endmodule : cias_status_word

// >>> dv/cias_req_model.sv
// interrupting requester model: contends on its level, returns a vector
`timescale 1ns/100ps
module cias_req_model (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ack_cycle,
	input wire logic [23:0] ack_addr,
	input wire logic [2:0] own_level,
	input wire logic [3:0] arb_prio,
	input wire logic [3:0] wait_cyc,
	input wire logic [7:0] vec,
	output logic contend_pin,
	output logic term_pin,
	output logic [7:0] data_pin
);
	logic [3:0] cnt;
	wire logic hit;
	assign hit = ack_cycle && ack_addr[3:1] == own_level && arb_prio != 4'h0;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 4'h0;
			contend_pin <= 1'b0;
			term_pin <= 1'b0;
		end else begin
			cnt <= hit ? cnt + 4'h1 : 4'h0;
			contend_pin <= hit && cnt >= wait_cyc;
			term_pin <= hit && cnt >= wait_cyc + 4'h2;
		end
	end
	// released bus shows the inverse, never a stale vector
	assign data_pin = term_pin ? vec : ~vec;
endmodule : cias_req_model

// >>> dv/cias_top_bench.sv
// self-checking bench for interrupt entry and status word
`timescale 1ns/100ps
module cias_top_bench import cias_pkg::*; ;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic irq_pending = 1'b0, at_boundary = 1'b0, higher_exc_busy = 1'b0, push_done = 1'b0;
	logic [2:0] irq_level = 3'h0, own_level = 3'h0;
	logic [31:0] pc_value = 32'h0;
	logic sr_op_valid = 1'b0, cc_load = 1'b0;
	cias_op_type sr_op = CIAS_OP_READ;
	logic [15:0] sr_wdata = 16'h0;
	logic [4:0] cc_in = 5'h0;
	logic [3:0] arb_prio = 4'h0, wait_cyc = 4'h0;
	logic [7:0] vec = 8'h0, data_pin, vector_num;
	logic contend_pin, term_pin, push_valid, ack_cycle, bus_error_strobe, spurious_exc;
	logic vector_valid, priv_violation;
	logic [31:0] push_data;
	logic [2:0] function_code_outputs;
	logic [23:0] ack_addr;
	logic [15:0] processor_status_word, sr_rdata;
	int n_tests = 0;
	int miscompares = 0;

	cias_top #(.SPUR_WAIT(8)) dut (.mclk(mclk), .rst_b(rst_b), .irq_pending(irq_pending),
		.irq_level(irq_level), .at_boundary(at_boundary), .higher_exc_busy(higher_exc_busy),
		.pc_value(pc_value), .push_done(push_done), .contend_pin(contend_pin),
		.term_pin(term_pin), .data_pin(data_pin), .sr_op_valid(sr_op_valid), .sr_op(sr_op),
		.sr_wdata(sr_wdata), .cc_load(cc_load), .cc_in(cc_in), .push_valid(push_valid),
		.push_data(push_data), .function_code_outputs(function_code_outputs),
		.ack_addr(ack_addr), .ack_cycle(ack_cycle), .bus_error_strobe(bus_error_strobe),
		.spurious_exc(spurious_exc), .vector_valid(vector_valid), .vector_num(vector_num),
		.processor_status_word(processor_status_word), .sr_rdata(sr_rdata),
		.priv_violation(priv_violation));

	cias_req_model peer (.mclk(mclk), .rst_b(rst_b), .ack_cycle(ack_cycle),
		.ack_addr(ack_addr), .own_level(own_level), .arb_prio(arb_prio),
		.wait_cyc(wait_cyc), .vec(vec), .contend_pin(contend_pin), .term_pin(term_pin),
		.data_pin(data_pin));

	always #2.5 mclk = ~mclk;

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// bounded wait, checked at falling edges where outputs have settled
	task automatic wait_until(input int sel, input string name);
		for (int i = 0; i < 60; i++) begin
			@(negedge mclk);
			if ((sel == 0 && push_valid === 1'b1) || (sel == 1 && ack_cycle === 1'b1) ||
					(sel == 2 && vector_valid === 1'b1) || (sel == 3 && bus_error_strobe === 1'b1))
				return;
		end
		chk(name, 1'b0, 1'b1);
		print_verdict();
	endtask : wait_until

	task automatic take_push(input logic [31:0] exp);
		wait_until(0, "push_valid");
		chk("push_data", push_data, exp);
		@(posedge mclk);
		push_done <= 1'b1;
		irq_pending <= 1'b0;
		@(posedge mclk);
		push_done <= 1'b0;
		@(negedge mclk);
	endtask : take_push

	task automatic sr_do(input cias_op_type o, input logic [15:0] d);
		@(posedge mclk);
		sr_op <= o;
		sr_wdata <= d;
		sr_op_valid <= 1'b1;
		@(posedge mclk);
		sr_op_valid <= 1'b0;
		@(negedge mclk);
	endtask : sr_do

	// pulse: reset lands while an entry is stacking, not only from idle
	task automatic t_reset(input bit pulse);
		if (pulse) begin
			@(posedge mclk);
			irq_level <= 3'h7;
			irq_pending <= 1'b1;
			wait_until(0, "push_before_reset");
			@(posedge mclk);
			rst_b <= 1'b0;
			irq_pending <= 1'b0;
			repeat (4) @(posedge mclk);
			rst_b <= 1'b1;
		end
		@(negedge mclk);
		chk("psw", processor_status_word, 16'h2700);
		chk("ack", ack_cycle, 1'b0);
		chk("fc", function_code_outputs, 3'h0);
		chk("addr", ack_addr, 24'h0);
		chk("push_valid", push_valid, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_status();
		sr_do(CIAS_OP_WRITE_CCR, 16'h00FF);
		chk("psw", processor_status_word, 16'h271F);
		sr_do(CIAS_OP_AND_IMMEDIATE_OP_CCR, 16'h0035);
		chk("psw", processor_status_word, 16'h2715);
		sr_do(CIAS_OP_WRITE_SR, 16'hFFFF);
		chk("psw", processor_status_word, 16'hE71F);
		sr_do(CIAS_OP_READ, 16'h0000);
		chk("rdata", sr_rdata, 16'hE71F);
		sr_do(CIAS_OP_AND_IMMEDIATE_OP_SR, 16'h12F3);
		chk("psw", processor_status_word, 16'h0213);
		sr_do(CIAS_OP_WRITE_SR, 16'h2700);
		chk("priv", priv_violation, 1'b1);
		chk("psw", processor_status_word, 16'h0213);
		sr_do(CIAS_OP_AND_IMMEDIATE_OP_SR, 16'h0000);
		chk("priv", priv_violation, 1'b1);
		chk("psw", processor_status_word, 16'h0213);
		sr_do(CIAS_OP_WRITE_CCR, 16'hFF0B);
		chk("psw", processor_status_word, 16'h020B);
		sr_do(CIAS_OP_READ, 16'h0000);
		chk("rdata", sr_rdata, 16'h000B);
		@(posedge mclk);
		cc_load <= 1'b1;
		cc_in <= 5'h06;
		@(posedge mclk);
		cc_load <= 1'b0;
		@(negedge mclk);
		chk("psw", processor_status_word, 16'h0206);
		$display("test status done");
	endtask : t_status

	task automatic t_entry(input logic [2:0] lvl, input logic [3:0] prio,
			input logic [3:0] slow, input logic [31:0] pc, input logic [15:0] psw_new);
		logic [15:0] old;
		old = processor_status_word;
		@(posedge mclk);
		own_level <= lvl;
		arb_prio <= prio;
		wait_cyc <= slow;
		vec <= {5'h15, lvl};
		pc_value <= pc;
		irq_level <= lvl;
		irq_pending <= 1'b1;
		at_boundary <= 1'b0;
		higher_exc_busy <= 1'b1;
		repeat (4) @(negedge mclk);
		chk("push_early", push_valid, 1'b0);
		@(posedge mclk);
		at_boundary <= 1'b1;
		higher_exc_busy <= 1'b0;
		take_push({16'h0000, old});
		chk("entry_bits", processor_status_word[15:13], 3'h1);
		take_push(pc);
		wait_until(1, "ack_cycle");
		chk("fc", function_code_outputs, 3'h7);
		chk("addr_hi", ack_addr[23:16], 8'hFF);
		chk("addr_mid", ack_addr[15:4], 12'hFFF);
		chk("addr_lo", ack_addr[3:0], {lvl, 1'b1});
		@(negedge mclk);
		chk("mask", processor_status_word[10:8], lvl);
		if (prio == 4'h0) begin
			wait_until(3, "bus_error");
			@(negedge mclk);
			chk("spurious", spurious_exc, 1'b1);
			chk("ack_end", ack_cycle, 1'b0);
		end else begin
			wait_until(2, "vector");
			chk("vector", vector_num, {5'h15, lvl});
		end
		chk("psw", processor_status_word, psw_new);
		$display("test entry level %0d done", lvl);
	endtask : t_entry

	// mask is 5 here: zero, lower and equal levels must be ignored
	task automatic t_refuse();
		logic [2:0] bad [3] = '{3'h0, 3'h3, 3'h5};
		for (int k = 0; k < 3; k++) begin
			@(posedge mclk);
			irq_level <= bad[k];
			irq_pending <= 1'b1;
			repeat (6) @(negedge mclk);
			chk("refused", push_valid, 1'b0);
		end
		@(posedge mclk);
		irq_pending <= 1'b0;
		$display("test refuse done");
	endtask : t_refuse

	initial begin
		#100000;
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset(1'b0);
		t_status();
		t_entry(3'h5, 4'h5, 4'h0, 32'h00001234, 16'h2506);
		t_refuse();
		// trace bits set so entry must clear them
		sr_do(CIAS_OP_WRITE_SR, 16'hC506);
		chk("psw", processor_status_word, 16'hC506);
		t_entry(3'h7, 4'h0, 4'h0, 32'h0000A5C0, 16'h2706);
		t_entry(3'h7, 4'h9, 4'h3, 32'hFFFF0002, 16'h2706);
		t_reset(1'b1);
		print_verdict();
	end
endmodule : cias_top_bench
